// file: design/smx_top.sv
// Signal mixer: APB registers, source selection, carrier sync and output
//
// Overview of operation
// - Output is the carrier chosen by the data level.
// - Data high mixes the upper carrier.
// - Data low mixes the lower carrier.
// - Mixing starts once software sets enable.
// - Clearing enable stops output, keeps selections.
// - Setting enable again resumes with kept selections.
// - Output pin low whenever enable is clear.
// - Data source field picks the data input.
// - Upper select field picks upper carrier input.
// - Lower select field picks lower carrier input.
// - Data choices: serial, capture, pulse-width, software, pin.
// - Carrier choices: capture, pulse-width, clocks, pin.
// - Output offered to the pin assignment logic.
// - Upper sync waits for upper carrier falling edge.
// - Lower sync waits for lower carrier falling edge.
// - Carrier invert bits flip each carrier first.
// - Output invert bit makes output idle high while enabled.
`timescale 1ns/1ps
`default_nettype none
module smx_top
  import smx_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Signal sources
  input wire smx_data_src_t data_src,
  input wire smx_car_src_t car_src,
  // Mixed output towards pin_output_assign
  output logic modulated_output_pin
);

  smx_state_t st_q;
  smx_state_t st_d;

  smx_data_src_t ds;
  smx_car_src_t cs;
  logic [(1<<SRC_W)-1:0] dvec;
  logic [(1<<CAR_W)-1:0] cvec;
  logic dsel;
  logic up_raw;
  logic lo_raw;
  logic up_car;
  logic lo_car;
  logic fall_h;
  logic fall_l;
  logic mix;
  logic setup;
  logic wr_go;
  logic hit;
  logic [7:0] rd_byte;

  // All source inputs come from other logic or pins, so they are synchronised
  smx_sync #(
    .W($bits(smx_data_src_t))
  ) u_sync_data (
    .clk(pclk),
    .rst_n(presetn),
    .a(data_src),
    .q(ds)
  );

  smx_sync #(
    .W($bits(smx_car_src_t))
  ) u_sync_car (
    .clk(pclk),
    .rst_n(presetn),
    .a(car_src),
    .q(cs)
  );

  // Candidate vectors, unused codes read as low
  assign dvec = {14'h0000, ds.spi_sck, ds.spi_sdo, ds.uart_tx, ds.pwm, ds.ccp,
                 st_q.swbit, ds.pin};
  assign cvec = {5'h00, cs.pwm, cs.ccp, cs.ref_clk, cs.hf_clk, cs.sys_clk,
                 cs.pin};

  smx_mux #(
    .SW(SRC_W)
  ) u_mux_data (
    .vec(dvec),
    .sel(st_q.data_sel),
    .y(dsel)
  );

  smx_mux #(
    .SW(CAR_W)
  ) u_mux_up (
    .vec(cvec),
    .sel(st_q.up_sel),
    .y(up_raw)
  );

  smx_mux #(
    .SW(CAR_W)
  ) u_mux_lo (
    .vec(cvec),
    .sel(st_q.lo_sel),
    .y(lo_raw)
  );

  assign up_car = up_raw ^ st_q.hinv;
  assign lo_car = lo_raw ^ st_q.linv;
  assign fall_h = st_q.up_prev & ~up_car;
  assign fall_l = st_q.lo_prev & ~lo_car;

  // Each carrier is gated by its side of the data signal
  assign mix = (up_car & (st_q.car == CAR_HIGH)) |
               (lo_car & (st_q.car == CAR_LOW));

  assign setup = psel & ~penable;
  assign wr_go = psel & penable & st_q.pready & pwrite & pstrb[0] & hit;

  // Address decode and read value
  always_comb begin
    hit = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      ADDR_CTL0: begin
        rd_byte[CTL0_EN_BIT] = st_q.en;
        rd_byte[CTL0_OUT_BIT] = st_q.out;
        rd_byte[CTL0_OINV_BIT] = st_q.oinv;
        rd_byte[CTL0_SWBIT_BIT] = st_q.swbit;
      end
      ADDR_CTL1: begin
        rd_byte[CTL1_HINV_BIT] = st_q.hinv;
        rd_byte[CTL1_HSYNC_BIT] = st_q.hsync;
        rd_byte[CTL1_LINV_BIT] = st_q.linv;
        rd_byte[CTL1_LSYNC_BIT] = st_q.lsync;
      end
      ADDR_SRC: rd_byte[SRC_W-1:0] = st_q.data_sel;
      ADDR_LO_CAR: rd_byte[CAR_W-1:0] = st_q.lo_sel;
      ADDR_UP_CAR: rd_byte[CAR_W-1:0] = st_q.up_sel;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    // Zero-wait answer: ready is raised for the single access cycle
    st_d.pready = setup;
    st_d.pslverr = setup & ~hit;
    if (setup) begin
      st_d.prdata = {24'h000000, rd_byte};
    end
    // Writes land at the completing edge; selections are never cleared by enable
    if (wr_go) begin
      unique case (paddr)
        ADDR_CTL0: begin
          st_d.en = pwdata[CTL0_EN_BIT];
          st_d.oinv = pwdata[CTL0_OINV_BIT];
          st_d.swbit = pwdata[CTL0_SWBIT_BIT];
        end
        ADDR_CTL1: begin
          st_d.hinv = pwdata[CTL1_HINV_BIT];
          st_d.hsync = pwdata[CTL1_HSYNC_BIT];
          st_d.linv = pwdata[CTL1_LINV_BIT];
          st_d.lsync = pwdata[CTL1_LSYNC_BIT];
        end
        ADDR_SRC: st_d.data_sel = pwdata[SRC_W-1:0];
        ADDR_LO_CAR: st_d.lo_sel = pwdata[CAR_W-1:0];
        ADDR_UP_CAR: st_d.up_sel = pwdata[CAR_W-1:0];
        default: st_d.data_sel = st_q.data_sel;
      endcase
    end
    st_d.up_prev = up_car;
    st_d.lo_prev = lo_car;
    // Carrier choice follows data; sync holds a switch until a falling edge
    if (!st_q.en) begin
      st_d.car = dsel ? CAR_HIGH : CAR_LOW;
    end else begin
      unique case (st_q.car)
        CAR_HIGH: begin
          if (!dsel && (!st_q.hsync || fall_h)) begin
            st_d.car = CAR_LOW;
          end
        end
        CAR_LOW: begin
          if (dsel && (!st_q.lsync || fall_l)) begin
            st_d.car = CAR_HIGH;
          end
        end
        default: st_d.car = CAR_LOW;
      endcase
    end
    st_d.out = st_q.en ? (mix ^ st_q.oinv) : 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign modulated_output_pin = st_q.out;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_setup;
    psel && !penable;
  endsequence

  sequence seq_wr_ctl0;
    wr_go && paddr == ADDR_CTL0;
  endsequence

  sequence seq_hold_high;
    st_q.en && st_q.car == CAR_HIGH && st_q.hsync && !fall_h;
  endsequence

  sequence seq_hold_low;
    st_q.en && st_q.car == CAR_LOW && st_q.lsync && !fall_l;
  endsequence

  AST_WR_EN:
    assert property (seq_wr_ctl0 ##0 pwdata[CTL0_EN_BIT] |=> st_q.en)
    else $error("enable write did not set enable");

  AST_STOP_KEEP:
    assert property (seq_wr_ctl0 ##0 !pwdata[CTL0_EN_BIT] |=>
                     !st_q.en && $stable(st_q.data_sel) && $stable(st_q.up_sel) &&
                     $stable(st_q.lo_sel))
    else $error("disable lost enable or selections");

  AST_OFF_LOW:
    assert property (!st_q.en |=> !st_q.out)
    else $error("output not low while disabled");

  AST_MIX_HIGH:
    assert property (st_q.en && st_q.car == CAR_HIGH |=>
                     st_q.out == ($past(up_car) ^ $past(st_q.oinv)))
    else $error("upper carrier not mixed");

  AST_MIX_LOW:
    assert property (st_q.en && st_q.car == CAR_LOW |=>
                     st_q.out == ($past(lo_car) ^ $past(st_q.oinv)))
    else $error("lower carrier not mixed");

  AST_HOLD_HIGH:
    assert property (seq_hold_high |=> st_q.car == CAR_HIGH)
    else $error("upper carrier left before its falling edge");

  AST_HOLD_LOW:
    assert property (seq_hold_low |=> st_q.car == CAR_LOW)
    else $error("lower carrier left before its falling edge");

  AST_SWBIT:
    assert property (st_q.data_sel == SRC_SWBIT |-> dsel == st_q.swbit)
    else $error("software bit not used as data");

  AST_IDLE_HIGH:
    assert property (st_q.en && st_q.oinv && !mix |=> st_q.out)
    else $error("inverted output not high when idle");

  AST_APB_READY:
    assert property (seq_setup |=> st_q.pready ##1 !st_q.pready)
    else $error("ready not a single access cycle");

  sequence seq_go_low;
    st_q.en && st_q.car == CAR_HIGH && !dsel;
  endsequence

  sequence seq_go_high;
    st_q.en && st_q.car == CAR_LOW && dsel;
  endsequence

  AST_SWITCH_LOW:
    assert property (seq_go_low ##0 (!st_q.hsync || fall_h) |=> st_q.car == CAR_LOW)
    else $error("lower carrier not taken on data low");

  AST_SWITCH_HIGH:
    assert property (seq_go_high ##0 (!st_q.lsync || fall_l) |=> st_q.car == CAR_HIGH)
    else $error("upper carrier not taken on data high");

  AST_OFF_FOLLOW:
    assert property (!st_q.en |=> st_q.car == ($past(dsel) ? CAR_HIGH : CAR_LOW))
    else $error("carrier state lost data while disabled");

  AST_APB_ERR:
    assert property (seq_setup ##0 !hit |=> st_q.pslverr && st_q.prdata == '0)
    else $error("unmapped access not refused");

endmodule
`default_nettype wire

// file: design/smx_pkg.sv
// Shared constants and types of the signal mixer
`default_nettype none
package smx_pkg;

  // APB geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Register indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CTL0 = 16'h0f51;
  localparam logic [ADDR_W-1:0] IDX_CTL1 = 16'h0f52;
  localparam logic [ADDR_W-1:0] IDX_SRC = 16'h0f53;
  localparam logic [ADDR_W-1:0] IDX_LO_CAR = 16'h0f54;
  localparam logic [ADDR_W-1:0] IDX_UP_CAR = 16'h0f55;
  localparam logic [ADDR_W-1:0] ADDR_CTL0 = IDX_CTL0 << 2;
  localparam logic [ADDR_W-1:0] ADDR_CTL1 = IDX_CTL1 << 2;
  localparam logic [ADDR_W-1:0] ADDR_SRC = IDX_SRC << 2;
  localparam logic [ADDR_W-1:0] ADDR_LO_CAR = IDX_LO_CAR << 2;
  localparam logic [ADDR_W-1:0] ADDR_UP_CAR = IDX_UP_CAR << 2;

  // Field positions of modulator_control_first
  localparam int CTL0_EN_BIT = 7;
  localparam int CTL0_OUT_BIT = 5;
  localparam int CTL0_OINV_BIT = 4;
  localparam int CTL0_SWBIT_BIT = 0;

  // Field positions of modulator_control_second
  localparam int CTL1_HINV_BIT = 5;
  localparam int CTL1_HSYNC_BIT = 4;
  localparam int CTL1_LINV_BIT = 1;
  localparam int CTL1_LSYNC_BIT = 0;

  // Select field widths
  localparam int SRC_W = 5;
  localparam int CAR_W = 4;

  // Data source codes: 0 pin, 1 software bit, 2-6 capture/compare,
  // 7-8 pulse-width, 9-13 serial transmit, 14-15 sync serial data,
  // 16-17 sync serial clock, others read as low
  localparam logic [SRC_W-1:0] SRC_PIN = 5'h00;
  localparam logic [SRC_W-1:0] SRC_SWBIT = 5'h01;

  // Carrier codes: 0 pin, 1 system clock, 2 fast internal clock,
  // 3 reference clock, 4-8 capture/compare, 9-10 pulse-width, others low
  localparam logic [CAR_W-1:0] CAR_PIN = 4'h0;

  // Register byte values after reset
  localparam logic [7:0] RST_CTL0 = 8'h00;
  localparam logic [7:0] RST_CTL1 = 8'h00;
  localparam logic [7:0] RST_SRC = 8'h00;
  localparam logic [7:0] RST_LO_CAR = 8'h00;
  localparam logic [7:0] RST_UP_CAR = 8'h00;

  // Which carrier is being mixed
  typedef enum logic [1:0] {
    CAR_LOW = 2'b01,
    CAR_HIGH = 2'b10
  } smx_car_t;

  // Candidate modulator data inputs
  typedef struct packed {
    logic [1:0] spi_sck;
    logic [1:0] spi_sdo;
    logic [4:0] uart_tx;
    logic [1:0] pwm;
    logic [4:0] ccp;
    logic pin;
  } smx_data_src_t;

  // Candidate carrier inputs, shared by both carrier selectors
  typedef struct packed {
    logic [1:0] pwm;
    logic [4:0] ccp;
    logic ref_clk;
    logic hf_clk;
    logic sys_clk;
    logic pin;
  } smx_car_src_t;

  // Whole state of the mixer top
  typedef struct packed {
    logic en;
    logic oinv;
    logic swbit;
    logic hinv;
    logic hsync;
    logic linv;
    logic lsync;
    logic [SRC_W-1:0] data_sel;
    logic [CAR_W-1:0] lo_sel;
    logic [CAR_W-1:0] up_sel;
    smx_car_t car;
    logic up_prev;
    logic lo_prev;
    logic out;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } smx_state_t;

  localparam smx_state_t STATE_RST = '{
    en: RST_CTL0[CTL0_EN_BIT],
    oinv: RST_CTL0[CTL0_OINV_BIT],
    swbit: RST_CTL0[CTL0_SWBIT_BIT],
    hinv: RST_CTL1[CTL1_HINV_BIT],
    hsync: RST_CTL1[CTL1_HSYNC_BIT],
    linv: RST_CTL1[CTL1_LINV_BIT],
    lsync: RST_CTL1[CTL1_LSYNC_BIT],
    data_sel: RST_SRC[SRC_W-1:0],
    lo_sel: RST_LO_CAR[CAR_W-1:0],
    up_sel: RST_UP_CAR[CAR_W-1:0],
    car: CAR_LOW,
    default: '0
  };

endpackage
`default_nettype wire

// file: design/smx_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module smx_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] a,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] flt;
  } smx_sync_st_t;

  smx_sync_st_t st_q;
  smx_sync_st_t st_d;

  // A bit moves only once the second and third stages agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = a;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.flt = ((st_q.s2 ~^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.flt);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.flt;

endmodule
`default_nettype wire

// file: design/smx_mux.sv
// One-of-many bit selector
`timescale 1ns/1ps
`default_nettype none
module smx_mux #(
  parameter int SW = 4
) (
  // Candidates and code
  input wire logic [(1<<SW)-1:0] vec,
  input wire logic [SW-1:0] sel,
  // Chosen bit
  output logic y
);

  assign y = vec[sel];

endmodule
`default_nettype wire

// file: verification/smx_src_model.sv
// Behavioural model of the on-chip signal sources that feed the mixer
`timescale 1ns/1ps
`default_nettype none
module smx_src_model
  import smx_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Levels requested by the bench
  input wire smx_data_src_t data_cfg,
  input wire smx_car_src_t car_cfg,
  // Sources towards the mixer
  output smx_data_src_t data_src,
  output smx_car_src_t car_src
);
  // Peripheral outputs move just after the clock, like on-chip sources
  always_ff @(posedge pclk) begin
    data_src <= data_cfg;
    car_src <= car_cfg;
  end
endmodule
`default_nettype wire

// file: verification/smx_top_tb_top.sv
// Self-checking bench of the signal mixer
`timescale 1ns/1ps
`default_nettype none
module smx_top_tb_top;
  import smx_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic modulated_output_pin;
  smx_data_src_t data_cfg = '0;
  smx_car_src_t car_cfg = '0;
  smx_data_src_t data_src;
  smx_car_src_t car_src;
  int miscompares = 0;
  int checks_done = 0;

  always #10 pclk = ~pclk;

  smx_src_model u_src (.pclk(pclk), .data_cfg(data_cfg), .car_cfg(car_cfg),
    .data_src(data_src), .car_src(car_src));

  smx_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .data_src(data_src), .car_src(car_src),
    .modulated_output_pin(modulated_output_pin));

  task finish_test;
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task chk(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
           input logic [3:0] s, output logic [DATA_W-1:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      finish_test();
    end
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [DATA_W-1:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, 4'hf, r, e);
  endtask

  task rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [DATA_W-1:0] r;
    logic e;
    apb(1'b0, a, '0, 4'hf, r, e);
    chk({24'h0, exp}, r);
  endtask

  // Lets sources pass the synchronisers and the output flop; looks mid-cycle
  task chko(input logic e);
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, e}, {31'h0, modulated_output_pin});
  endtask

  task t_reset;
    logic [DATA_W-1:0] r;
    logic e;
    rd(ADDR_CTL0, 8'h00);
    rd(ADDR_CTL1, 8'h00);
    rd(ADDR_SRC, 8'h00);
    rd(ADDR_LO_CAR, 8'h00);
    rd(ADDR_UP_CAR, 8'h00);
    chko(1'b0);
    apb(1'b0, 16'h0000, '0, 4'hf, r, e);
    chk(32'h1, {31'h0, e});
    chk(32'h0, r);
  endtask

  task t_mix;
    logic [DATA_W-1:0] r;
    logic e;
    car_cfg <= smx_car_src_t'(11'h010);
    wr(ADDR_UP_CAR, 8'h04);
    wr(ADDR_LO_CAR, 8'h00);
    wr(ADDR_SRC, 8'h01);
    wr(ADDR_CTL0, 8'h81);
    chko(1'b1);
    rd(ADDR_CTL0, 8'ha1);
    wr(ADDR_CTL0, 8'h80);
    chko(1'b0);
    car_cfg <= smx_car_src_t'(11'h011);
    chko(1'b1);
    wr(ADDR_CTL1, 8'h02);
    chko(1'b0);
    rd(ADDR_CTL1, 8'h02);
    wr(ADDR_CTL1, 8'h00);
    wr(ADDR_CTL0, 8'h90);
    chko(1'b0);
    car_cfg <= smx_car_src_t'(11'h010);
    chko(1'b1);
    car_cfg <= smx_car_src_t'(11'h011);
    wr(ADDR_CTL0, 8'h10);
    chko(1'b0);
    rd(ADDR_SRC, 8'h01);
    rd(ADDR_UP_CAR, 8'h04);
    apb(1'b1, ADDR_SRC, 32'h0000001f, 4'he, r, e);
    chk(32'h0, {31'h0, e});
    rd(ADDR_SRC, 8'h01);
    wr(ADDR_CTL0, 8'h80);
    chko(1'b1);
  endtask

  task t_data_sel;
    int b;
    car_cfg <= smx_car_src_t'(11'h010);
    for (int c = 0; c < 18; c++) begin
      if (c != 1) begin
        b = (c == 0) ? 0 : c - 1;
        data_cfg <= smx_data_src_t'(~(17'h1 << b));
        wr(ADDR_SRC, c[7:0]);
        chko(1'b0);
        data_cfg <= smx_data_src_t'(17'h1 << b);
        chko(1'b1);
      end
    end
    data_cfg <= smx_data_src_t'(17'h1ffff);
    wr(ADDR_SRC, 8'h12);
    chko(1'b0);
  endtask

  task t_car_sel;
    wr(ADDR_SRC, 8'h01);
    wr(ADDR_CTL0, 8'h81);
    for (int c = 0; c < 11; c++) begin
      car_cfg <= smx_car_src_t'(11'h1 << c);
      wr(ADDR_UP_CAR, c[7:0]);
      chko(1'b1);
      car_cfg <= smx_car_src_t'(~(11'h1 << c));
      chko(1'b0);
    end
  endtask

  task t_sync;
    wr(ADDR_UP_CAR, 8'h04);
    wr(ADDR_CTL1, 8'h10);
    car_cfg <= smx_car_src_t'(11'h010);
    chko(1'b1);
    wr(ADDR_CTL0, 8'h80);
    chko(1'b1);
    car_cfg <= smx_car_src_t'(11'h001);
    chko(1'b1);
    wr(ADDR_CTL1, 8'h01);
    chko(1'b1);
    wr(ADDR_CTL0, 8'h81);
    chko(1'b1);
    car_cfg <= smx_car_src_t'(11'h000);
    chko(1'b0);
    car_cfg <= smx_car_src_t'(11'h010);
    chko(1'b1);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mix();
    t_data_sel();
    t_car_sel();
    t_sync();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
